// *** core/lcd_segment_keyscan_mux.sv ***
// Purpose: Segment pin drive from display memory and key scan port registers
// Assumes: Frame timing gives slot boundary and frame start strobes
// Notes: Notes on behaviour follow
// Notes on behaviour
// [R1] Each of the 24 segment lines takes its byte from display memory, lowest address first.
// [R2] Bit k of a segment byte is used while common line k is the active slot.
// [R3] A one drives the select level and a zero the deselect level on segment lines 0 to 23.
// [R4] In a key scan slot the upper segment pins come from port registers 14 and 15.
// [R5] Pins 16 to 23 take low nibbles in the first half and high nibbles in the latter half.
// [R6] With key scanning enabled, slices plus one scan slots are added to every frame.
// [R7] Bits above the slot count in each byte are ignored and stay as plain storage, bar the upper nibble of bytes 0 to 3.
// [R8] The upper nibble of the first four bytes always reads as zero.
// [R9] Software should load the latter half as the inverse of the first half.
// [R10] The pin source changes only on a slot boundary.
`timescale 1ns/1ps
module lcd_segment_keyscan_mux (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic key_scan_enable,
  input wire seg_drive_pkg::duty_mode_type duty_mode,
  input wire logic slot_boundary,
  input wire logic frame_start,
  input wire logic mem_write,
  input wire logic [seg_drive_pkg::mem_addr_width-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  input wire logic port14_write,
  input wire logic port15_write,
  input wire logic [7:0] port_wdata,
  output logic [7:0] port14,
  output logic [7:0] port15,
  output logic [1:0] common_line_active,
  output logic scan_slot,
  output logic scan_latter_half,
  output logic [seg_drive_pkg::seg_count-1:0] segment_line_select
);
  import seg_drive_pkg::*;

  logic [7:0] disp_mem [0:seg_count-1];
  // Four bits: four slices plus five scan slots make nine slots a frame
  logic [3:0] slot_index;
  wire [3:0] slices = {2'b00, duty_mode} + 4'h1;
  wire [3:0] frame_slots = key_scan_enable ? slices + slices + 4'h1 : slices; // [R6]
  wire [3:0] next_slot = (frame_start || slot_index + 4'h1 >= frame_slots) ?
    4'h0 : slot_index + 4'h1;
  wire next_scan = next_slot >= slices; // [R6]
  wire [3:0] scan_pos = next_slot - slices;
  // First scan slot pairs with the first half, the rest alternate halves
  wire next_latter = next_scan && scan_pos[0];
  wire [1:0] next_com = next_scan ? common_line_active : next_slot[1:0];
  wire mem_addr_ok = mem_addr < 5'd24;
  wire upper_clear = mem_addr <= upper_clear_last;
  wire [7:0] mem_wmask = upper_clear ? 8'h0f : 8'hff; // [R8]

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      slot_index <= 4'h0;
      common_line_active <= 2'h0;
      scan_slot <= 1'b0;
      scan_latter_half <= 1'b0;
    end else if (clk_en && slot_boundary) begin
      slot_index <= next_slot;
      common_line_active <= next_com; // [R2]
      scan_slot <= next_scan; // [R10]
      scan_latter_half <= next_latter;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en && mem_write && mem_addr_ok) begin
      disp_mem[mem_addr] <= mem_wdata & mem_wmask; // [R8]
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_rdata <= mem_reset_value;
      port14 <= port_reset_value;
      port15 <= port_reset_value;
    end else if (clk_en) begin
      mem_rdata <= mem_addr_ok ? disp_mem[mem_addr] & mem_wmask : 8'h00; // [R8]
      if (port14_write) begin
        port14 <= port_wdata;
      end
      if (port15_write) begin
        port15 <= port_wdata;
      end
    end
  end

  // Software keeps ports inverted between halves to drain panel charge
  wire [7:0] scan_bits = next_latter ? {port15[7:4], port14[7:4]} :
    {port15[3:0], port14[3:0]}; // [R5] [R9]
  wire [1:0] bit_sel = next_com; // [R2]
  // Unused upper bits are treated as zero on the pins for the lower duty modes
  wire bit_used = {1'b0, bit_sel} <= {1'b0, duty_mode}; // [R7]

  genvar s;
  generate
    for (s = 0; s < seg_count; s++) begin : g_seg
      wire [7:0] seg_byte = disp_mem[s]; // [R1]
      wire disp_level = bit_used & seg_byte[bit_sel]; // [R3]
      wire pick;
      if (s >= scan_first_seg) begin : g_scan
        assign pick = next_scan ? scan_bits[s-scan_first_seg] : disp_level; // [R4]
      end else begin : g_plain
        assign pick = next_scan ? 1'b0 : disp_level;
      end
      seg_level_cell u_cell (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .slot_boundary(slot_boundary),
        .next_level(pick),
        .level(segment_line_select[s])
      );
    end
  endgenerate
endmodule // lcd_segment_keyscan_mux

// *** core/seg_drive_pkg.sv ***
// Purpose: Shared constants for the segment output and key scan block
// Assumes: One core clock, slot timing supplied by the frame timing logic
// Notes: Display memory is 24 bytes, one per segment line
package seg_drive_pkg;
  localparam int seg_count = 24;
  localparam int com_count = 4;
  localparam int scan_first_seg = 16;
  localparam int scan_seg_count = 8;
  localparam int mem_addr_width = 5;
  localparam logic [4:0] upper_clear_last = 5'h03;
  localparam logic [7:0] mem_reset_value = 8'h00;
  localparam logic [7:0] port_reset_value = 8'h00;
  typedef enum logic [1:0] {
    mode_static_type_v, mode_two_slot, mode_three_slot, mode_four_slot
  } duty_mode_type;
  typedef enum logic [1:0] {slot_display, slot_scan_first, slot_scan_latter} slot_kind_type;
endpackage

// *** core/seg_level_cell.sv ***
// Purpose: One segment pin level register with slot-boundary update
// Assumes: Caller presents the level already decoded
// Notes: Output changes only on the boundary strobe
`timescale 1ns/1ps
module seg_level_cell (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic slot_boundary,
  input wire logic next_level,
  output logic level
);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      level <= 1'b0;
    end else if (clk_en && slot_boundary) begin
      level <= next_level; // [R10]
    end
  end
endmodule // seg_level_cell

// *** test/key_matrix_model.sv ***
// Purpose: key matrix model. Assumes: every key closed. Notes: pull-ups idle high
`timescale 1ns/1ps
module key_matrix_model (
  input wire logic scan_slot,
  input wire logic [7:0] scan_pins,
  output logic [7:0] key_lines
);
  assign key_lines = scan_slot ? scan_pins : 8'hff;
endmodule // key_matrix_model

// *** test/seg_mux_properties.sv ***
// Purpose: pin checks. Assumes: ports idle in scan slots. Notes: bound below
`timescale 1ns/1ps
module seg_props (
  input wire logic core_clk, reset_n, slot_boundary, key_scan_enable, scan_slot,
  input wire logic scan_latter_half,
  input wire seg_drive_pkg::duty_mode_type duty_mode,
  input wire logic [4:0] mem_addr,
  input wire logic [7:0] mem_rdata, port14, port15,
  input wire logic [1:0] common_line_active,
  input wire logic [23:0] segment_line_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_pins_hold: assert property (!slot_boundary |=> $stable(segment_line_select))
    else $error("pins moved");
  a_scan_low: assert property (scan_slot |-> segment_line_select[15:0] == 16'h0)
    else $error("low pins");
  a_scan_pins: assert property (scan_slot |-> segment_line_select[23:16] ==
    (scan_latter_half ? {port15[7:4], port14[7:4]} : {port15[3:0], port14[3:0]})) else $error("scan");
  a_scan_order: assert property ($rose(scan_slot) |-> !scan_latter_half)
    else $error("half");
  a_scan_enabled: assert property (scan_slot |-> key_scan_enable)
    else $error("enable");
  a_com_range: assert property (!scan_slot |-> common_line_active <= 2'(duty_mode))
    else $error("com");
  a_upper_zero: assert property (mem_addr < 5'h04 |=> mem_rdata[7:4] == 4'h0)
    else $error("upper");
  a_read_refused: assert property (mem_addr > 5'h17 |=> mem_rdata == 8'h00)
    else $error("addr");
endmodule // seg_props
bind lcd_segment_keyscan_mux seg_props checks (.*);

// *** test/lcd_segment_keyscan_mux_bench.sv ***
// Purpose: mux bench. Assumes: clk_en tied high. Notes: boundary every 2 cycles
`timescale 1ns/1ps
module lcd_segment_keyscan_mux_bench;
  import seg_drive_pkg::*;
  logic core_clk = 0, reset_n = 0, clk_en = 1, key_scan_enable = 0, slot_boundary = 0;
  logic frame_start = 0, mem_write = 0, port14_write = 0, port15_write = 0;
  logic scan_slot, scan_latter_half;
  duty_mode_type duty_mode = mode_four_slot;
  logic [4:0] mem_addr = 0;
  logic [7:0] mem_wdata = 0, port_wdata = 8'ha5, mem_rdata, port14, port15, key_lines;
  logic [1:0] common_line_active;
  logic [23:0] segment_line_select, want;
  int errors = 0, comparisons = 0, n, t, x;
`define chk(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t %h %h", $time, a, b); end end
  lcd_segment_keyscan_mux uut (.*);
  key_matrix_model panel (.scan_slot, .scan_pins(segment_line_select[23:16]), .key_lines);
  initial forever #2 core_clk = ~core_clk;
  function logic [7:0] ev(int i); return 8'(i * 29) & (i < 4 ? 8'h0f : 8'hff); endfunction
  task frame_test(duty_mode_type m, logic scan);
    {reset_n, duty_mode, key_scan_enable} = {1'b0, m, scan};
    repeat (10) @(negedge core_clk);
    reset_n = 1;
    n = int'(m) + 1;
    t = scan ? 2 * n + 1 : n;
    for (int i = 0; i < 27; i++) begin
      {mem_write, port14_write, port15_write} = {i < 25, i == 25, i == 26};
      {mem_addr, mem_wdata} = {5'(i), 8'(i * 29)};
      port_wdata = i == 26 ? 8'h3c : 8'ha5;
      @(negedge core_clk);
    end
    {mem_write, port14_write, port15_write} = 3'b000;
    `chk(port14, 8'ha5)
    `chk(port15, 8'h3c)
    for (int j = 2; j < 26; j += 11) begin
      mem_addr = 5'(j);
      @(negedge core_clk);
      `chk(mem_rdata, j < 24 ? ev(j) : 8'h00)
    end
    for (int s = 0; s <= t; s++) begin
      {slot_boundary, frame_start} = {1'b1, s == 0};
      @(negedge core_clk);
      slot_boundary = 0;
      @(negedge core_clk);
      x = s % t;
      want = {(x - n) % 2 ? 8'h3a : 8'hc5, 16'h0};
      for (int i = 0; i < 24 && x < n; i++) want[i] = 1'(ev(i) >> x);
      `chk(segment_line_select, want)
      `chk(key_lines, x < n ? 8'hff : want[23:16])
      `chk(scan_slot, x >= n)
      `chk(scan_latter_half, x >= n && (x - n) % 2 == 1)
      if (x < n) `chk(common_line_active, 2'(x))
    end
    $display("frame test done");
  endtask
  task report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    for (int m = 0; m < 4; m++) frame_test(duty_mode_type'(m), m[0]);
    report_and_stop();
  end
  initial begin #20us; errors++; report_and_stop(); end
endmodule // lcd_segment_keyscan_mux_bench
